// File: core/uart_interrupt_status_clear.sv
// Interrupt status and clear register with gated register port access
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Register reachable only when line control is 0xBF and special access bit set.
// - Status register resets to all zeros.
// - Bit 7 flags a CTS/RTS handshake line change interrupt.
// - Bit 6 flags a received flow-off or special character interrupt.
// - Bit 5 flags a modem status line interrupt.
// - Bit 4 flags a transmit holding interrupt.
// - Bit 3 flags a receiver timeout interrupt.
// - Bit 2 flags a receive holding data interrupt.
// - Bit 1 flags a receive line error interrupt.
// - Writing one to bit 0 clears all status flags whose source is not asserted in the same cycle.
// - Clear-all bit returns to zero by itself; reads show it low.
// - Special register access gated on special function bit 2.
module uart_interrupt_status_clear (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic [7:0] line_control_i,
  input  wire logic [7:0] special_function_i,
  input  wire logic       handshake_change_i,
  input  wire logic       flow_off_special_i,
  input  wire logic       modem_change_i,
  input  wire logic       transmit_holding_i,
  input  wire logic       receive_timeout_i,
  input  wire logic       receive_holding_i,
  input  wire logic       line_error_i,
  output logic            reg_hit_o,
  output logic [7:0]      reg_rdata_o,
  output logic [7:0]      int_status_o,
  output logic            int_pending_o
);
  import int_status_pkg::*;

  // Access decode
  logic       line_control_match;
  logic       special_access_en;
  logic       unlocked;
  logic       offset_match;
  logic       sel;
  logic       wr_accept;
  logic       rd_accept;
  logic       clear_all;

  // Source request vector
  logic [7:0] src_vec;

  // Handshake line change
  logic       handshake_set;
  logic       handshake_flag_r;

  // Flow-off or special character
  logic       flow_off_set;
  logic       flow_off_flag_r;

  // Modem line change
  logic       modem_set;
  logic       modem_flag_r;

  // Transmit holding
  logic       transmit_set;
  logic       transmit_flag_r;

  // Receiver timeout
  logic       timeout_set;
  logic       timeout_flag_r;

  // Receive holding
  logic       receive_set;
  logic       receive_flag_r;

  // Receive line error
  logic       line_error_set;
  logic       line_error_flag_r;

  // Status, read path and pending
  logic [7:0] status_vec;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       pending_r;

  // Unlock condition
  assign line_control_match = (line_control_i == LINE_CONTROL_UNLOCK);
  assign special_access_en  = special_function_i[SPECIAL_ACCESS_BIT];
  assign unlocked           = line_control_match && special_access_en;

  // Offset match and strobes
  assign offset_match = (reg_addr_i == ADDR_INT_STATUS_CLEAR);
  assign sel          = unlocked && offset_match;
  assign wr_accept    = sel && reg_wr_i;
  assign rd_accept    = sel && reg_rd_i;

  // Clear-all request
  assign clear_all = wr_accept && reg_wdata_i[BIT_CLEAR_ALL_STATUS];

  // Hit flag
  assign reg_hit_o = sel;

  // Source request map
  always_comb begin
    src_vec                       = 8'h00;
    src_vec[BIT_HANDSHAKE_CHANGE] = handshake_change_i;
    src_vec[BIT_FLOW_OFF_SPECIAL] = flow_off_special_i;
    src_vec[BIT_MODEM_CHANGE]     = modem_change_i;
    src_vec[BIT_TRANSMIT_HOLDING] = transmit_holding_i;
    src_vec[BIT_RECEIVE_TIMEOUT]  = receive_timeout_i;
    src_vec[BIT_RECEIVE_HOLDING]  = receive_holding_i;
    src_vec[BIT_LINE_ERROR]       = line_error_i;
  end

  // Handshake line change flag
  assign handshake_set = src_vec[BIT_HANDSHAKE_CHANGE];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      handshake_flag_r <= INT_STATUS_RESET[BIT_HANDSHAKE_CHANGE];
    end else if (clear_all) begin
      if (handshake_set) begin
        handshake_flag_r <= 1'b1;
      end else begin
        handshake_flag_r <= 1'b0;
      end
    end else if (handshake_set) begin
      handshake_flag_r <= 1'b1;
    end else begin
      handshake_flag_r <= handshake_flag_r;
    end
  end

  // Flow-off or special character flag
  assign flow_off_set = src_vec[BIT_FLOW_OFF_SPECIAL];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flow_off_flag_r <= INT_STATUS_RESET[BIT_FLOW_OFF_SPECIAL];
    end else if (clear_all) begin
      if (flow_off_set) begin
        flow_off_flag_r <= 1'b1;
      end else begin
        flow_off_flag_r <= 1'b0;
      end
    end else if (flow_off_set) begin
      flow_off_flag_r <= 1'b1;
    end else begin
      flow_off_flag_r <= flow_off_flag_r;
    end
  end

  // Modem line change flag
  assign modem_set = src_vec[BIT_MODEM_CHANGE];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      modem_flag_r <= INT_STATUS_RESET[BIT_MODEM_CHANGE];
    end else if (clear_all) begin
      if (modem_set) begin
        modem_flag_r <= 1'b1;
      end else begin
        modem_flag_r <= 1'b0;
      end
    end else if (modem_set) begin
      modem_flag_r <= 1'b1;
    end else begin
      modem_flag_r <= modem_flag_r;
    end
  end

  // Transmit holding flag
  assign transmit_set = src_vec[BIT_TRANSMIT_HOLDING];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transmit_flag_r <= INT_STATUS_RESET[BIT_TRANSMIT_HOLDING];
    end else if (clear_all) begin
      if (transmit_set) begin
        transmit_flag_r <= 1'b1;
      end else begin
        transmit_flag_r <= 1'b0;
      end
    end else if (transmit_set) begin
      transmit_flag_r <= 1'b1;
    end else begin
      transmit_flag_r <= transmit_flag_r;
    end
  end

  // Receiver timeout flag
  assign timeout_set = src_vec[BIT_RECEIVE_TIMEOUT];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timeout_flag_r <= INT_STATUS_RESET[BIT_RECEIVE_TIMEOUT];
    end else if (clear_all) begin
      if (timeout_set) begin
        timeout_flag_r <= 1'b1;
      end else begin
        timeout_flag_r <= 1'b0;
      end
    end else if (timeout_set) begin
      timeout_flag_r <= 1'b1;
    end else begin
      timeout_flag_r <= timeout_flag_r;
    end
  end

  // Receive holding flag
  assign receive_set = src_vec[BIT_RECEIVE_HOLDING];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      receive_flag_r <= INT_STATUS_RESET[BIT_RECEIVE_HOLDING];
    end else if (clear_all) begin
      if (receive_set) begin
        receive_flag_r <= 1'b1;
      end else begin
        receive_flag_r <= 1'b0;
      end
    end else if (receive_set) begin
      receive_flag_r <= 1'b1;
    end else begin
      receive_flag_r <= receive_flag_r;
    end
  end

  // Receive line error flag
  assign line_error_set = src_vec[BIT_LINE_ERROR];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_error_flag_r <= INT_STATUS_RESET[BIT_LINE_ERROR];
    end else if (clear_all) begin
      if (line_error_set) begin
        line_error_flag_r <= 1'b1;
      end else begin
        line_error_flag_r <= 1'b0;
      end
    end else if (line_error_set) begin
      line_error_flag_r <= 1'b1;
    end else begin
      line_error_flag_r <= line_error_flag_r;
    end
  end

  // Status assembly
  always_comb begin
    status_vec                       = 8'h00;
    status_vec[BIT_HANDSHAKE_CHANGE] = handshake_flag_r;
    status_vec[BIT_FLOW_OFF_SPECIAL] = flow_off_flag_r;
    status_vec[BIT_MODEM_CHANGE]     = modem_flag_r;
    status_vec[BIT_TRANSMIT_HOLDING] = transmit_flag_r;
    status_vec[BIT_RECEIVE_TIMEOUT]  = timeout_flag_r;
    status_vec[BIT_RECEIVE_HOLDING]  = receive_flag_r;
    status_vec[BIT_LINE_ERROR]       = line_error_flag_r;
    status_vec[BIT_CLEAR_ALL_STATUS] = 1'b0;
  end

  // Read data next value
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_accept) begin
      rdata_nxt[BIT_HANDSHAKE_CHANGE] = handshake_flag_r;
      rdata_nxt[BIT_FLOW_OFF_SPECIAL] = flow_off_flag_r;
      rdata_nxt[BIT_MODEM_CHANGE]     = modem_flag_r;
      rdata_nxt[BIT_TRANSMIT_HOLDING] = transmit_flag_r;
      rdata_nxt[BIT_RECEIVE_TIMEOUT]  = timeout_flag_r;
      rdata_nxt[BIT_RECEIVE_HOLDING]  = receive_flag_r;
      rdata_nxt[BIT_LINE_ERROR]       = line_error_flag_r;
      rdata_nxt[BIT_CLEAR_ALL_STATUS] = 1'b0;
    end
  end

  // Read data register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= INT_STATUS_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Pending flag register, tracks the next status
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= (|src_vec)
                   || (!clear_all && (|status_vec));
    end
  end

  // Outputs
  assign reg_rdata_o   = rdata_r;
  assign int_status_o  = status_vec;
  assign int_pending_o = pending_r;
endmodule : uart_interrupt_status_clear
`default_nettype wire

// File: core/int_status_pkg.sv
// Constants for the interrupt status and clear register
`default_nettype none
package int_status_pkg;
  localparam logic [7:0] ADDR_INT_STATUS_CLEAR = 8'h0F;
  localparam logic [7:0] LINE_CONTROL_UNLOCK   = 8'hBF;
  localparam int         SPECIAL_ACCESS_BIT    = 2;
  localparam logic [7:0] INT_STATUS_RESET      = 8'h00;
  localparam int         BIT_HANDSHAKE_CHANGE  = 7;
  localparam int         BIT_FLOW_OFF_SPECIAL  = 6;
  localparam int         BIT_MODEM_CHANGE      = 5;
  localparam int         BIT_TRANSMIT_HOLDING  = 4;
  localparam int         BIT_RECEIVE_TIMEOUT   = 3;
  localparam int         BIT_RECEIVE_HOLDING   = 2;
  localparam int         BIT_LINE_ERROR        = 1;
  localparam int         BIT_CLEAR_ALL_STATUS  = 0;
  localparam int         NUM_SOURCES           = 7;
endpackage : int_status_pkg
`default_nettype wire

// File: verif/status_checker_properties.sv
// Concurrent checks on the interrupt status and clear register
`timescale 1ns/1ps
`default_nettype none
module status_checker (
  input wire logic       clock_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] line_control_i,
  input wire logic [7:0] special_function_i,
  input wire logic       handshake_change_i,
  input wire logic       flow_off_special_i,
  input wire logic       modem_change_i,
  input wire logic       transmit_holding_i,
  input wire logic       receive_timeout_i,
  input wire logic       receive_holding_i,
  input wire logic       line_error_i,
  input wire logic       reg_hit_o,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] int_status_o,
  input wire logic       int_pending_o
);
  logic [7:0] src_w;
  logic       clr_w;
  assign src_w = {handshake_change_i, flow_off_special_i, modem_change_i, transmit_holding_i,
                  receive_timeout_i, receive_holding_i, line_error_i, 1'b0};
  assign clr_w = reg_hit_o && reg_wr_i && reg_wdata_i[0];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_rd_data: assert property (reg_hit_o && reg_rd_i |=>
    reg_rdata_o == $past(int_status_o)) else $error("read data differs from status");
  a_pend_or: assert property (int_pending_o == |int_status_o)
    else $error("pending differs from status");
  a_reset_zero: assert property (disable iff (1'b0) !arst_n_i |-> int_status_o == 8'h00)
    else $error("status not zero in reset");
  a_gate_closed: assert property (
    (line_control_i != 8'hBF || !special_function_i[2]) |-> !reg_hit_o)
    else $error("access open while locked");
  a_hit_addr: assert property (reg_hit_o |-> reg_addr_i == 8'h0F)
    else $error("hit on wrong offset");
  a_clear_all: assert property (clr_w |=> int_status_o == $past(src_w))
    else $error("clear all wrong");
  a_flag_hold: assert property (
    !clr_w |=> int_status_o == ($past(int_status_o) | $past(src_w)))
    else $error("flag not set or held");
  a_clear_low: assert property (!int_status_o[0] && !reg_rdata_o[0])
    else $error("clear bit reads high");
endmodule : status_checker
bind uart_interrupt_status_clear status_checker i_chk (.*);
`default_nettype wire

// File: verif/testbench.sv
// Bench for the interrupt status and clear register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [23:0] OPEN = 24'hBF040F;
  logic        clock_i     = 1'b0;
  logic        arst_n_i    = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_wdata_i = 8'h01;
  logic        reg_hit_o;
  logic        int_pending_o;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  int_status_o;
  logic [23:0] cfg         = OPEN;
  logic [7:1]  s           = '0;
  int          err_total   = 0;
  int          n_tests     = 0;
  always #5 clock_i = ~clock_i;
  uart_interrupt_status_clear i_dut (.*, .line_control_i(cfg[23:16]), .reg_addr_i(cfg[7:0]),
    .special_function_i(cfg[15:8]), .handshake_change_i(s[7]), .flow_off_special_i(s[6]),
    .modem_change_i(s[5]), .transmit_holding_i(s[4]), .receive_timeout_i(s[3]),
    .receive_holding_i(s[2]), .line_error_i(s[1]));
  task automatic chk(input logic [7:0] v, input logic [7:0] e, input string m);
    n_tests++;
    if (v !== e) begin
      err_total++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] d, input logic [23:0] c);
    @(negedge clock_i);
    reg_wr_i    = w;
    reg_rd_i    = !w;
    reg_wdata_i = d;
    cfg         = c;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cfg      = OPEN;
    #1;
  endtask : acc
  task automatic summarize();
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    #1;
    arst_n_i = 1'b0;
    repeat (10) @(negedge clock_i);
    chk(int_status_o, 8'h00, "reset status");
    chk({7'h00, int_pending_o}, 8'h00, "reset pending");
    arst_n_i = 1'b1;
    for (int i = 1; i < 8; i++) begin
      @(negedge clock_i);
      s[i] = 1'b1;
      cfg  = OPEN ^ (24'h1 << i % 3 * 10);
      #1;
      chk({7'h00, reg_hit_o}, 8'h00, "locked hit");
      acc(1'b1, 8'h01, OPEN ^ (24'h1 << i % 3 * 10));
      s = '0;
      chk(int_status_o, 8'h01 << i, "flag set");
      chk({7'h00, int_pending_o}, 8'h01, "pending set");
      chk({7'h00, reg_hit_o}, 8'h01, "open hit");
      acc(1'b0, 8'h00, OPEN);
      chk(reg_rdata_o, 8'h01 << i, "read flag");
      acc(1'b1, 8'h01, OPEN);
      chk(int_status_o, 8'h00, "clear all");
      chk({7'h00, int_pending_o}, 8'h00, "pending clear");
    end
    @(negedge clock_i);
    s[7] = 1'b1;
    acc(1'b1, 8'h00, OPEN);
    s = '0;
    chk(int_status_o, 8'h80, "write zero keeps");
    s[1] = 1'b1;
    acc(1'b1, 8'h01, OPEN);
    s = '0;
    chk(int_status_o, 8'h02, "set wins clear");
    acc(1'b0, 8'h00, OPEN);
    chk(reg_rdata_o, 8'h02, "read after clear");
    @(negedge clock_i);
    arst_n_i = 1'b0;
    #1;
    chk(int_status_o, 8'h00, "mid reset status");
    chk(reg_rdata_o, 8'h00, "mid reset read");
    repeat (2) @(negedge clock_i);
    arst_n_i = 1'b1;
    acc(1'b0, 8'h00, OPEN);
    chk(reg_rdata_o, 8'h00, "read after reset");
    summarize();
  end
endmodule : testbench
`default_nettype wire
